/* hw/region_map_translation.sv */
`timescale 1ns/10ps
module region_map_translation #(
  parameter int PID_W  = 8,
  parameter int HINT_W = 6
) (
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  // axi4-lite slave
  input  wire logic [9:0]                     s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [9:0]                     s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // translation request from the pipeline
  input  wire logic                           xlat_valid,
  input  wire logic [31:0]                    xlat_vaddr,
  input  wire region_map_pkg::mode_type       xlat_mode,
  input  wire region_map_pkg::kind_type       xlat_kind,
  // tlb side
  input  wire logic [PID_W-1:0]               tlb_task_ident,
  input  wire logic                           tlb_miss,
  input  wire logic                           tlb_prot_viol,
  input  wire logic [HINT_W-1:0]              tlb_victim,
  output logic                                tlb_task_ok,
  output logic [1:0]                          page_size_sel,
  output logic [4:0]                          page_shift,
  // region result, one cycle after the request
  output logic                                res_valid,
  output logic                                res_region_hit,
  output logic [31:0]                         res_paddr,
  output logic                                res_io_space,
  output logic [1:0]                          user_ctrl_out,
  output logic                                data_prot_viol,
  output logic                                instr_prot_viol
);

  // ==========================================================
  // registers
  // ==========================================================
  logic [31:0] cfg_r;
  logic [31:0] rmap_addr_r;
  logic [31:0] rmap_ctrl_r;
  logic [HINT_W-1:0] hint_r;
  logic [1:0]  page_size_r;

  logic [7:0]  current_process_id;
  logic [15:0] virt_base;
  logic [15:0] phys_base;
  logic [3:0]  region_size;
  logic [1:0]  user_ctrl_bits;
  logic [7:0]  task_ident;
  logic [15:0] keep_mask;
  logic [15:0] va_upper;
  logic [15:0] va_lower;

  assign current_process_id = cfg_r[region_map_pkg::PID_LO +: 8];
  assign virt_base          = rmap_addr_r[region_map_pkg::VBASE_LO +: 16];
  assign phys_base          = rmap_addr_r[region_map_pkg::PBASE_LO +: 16];
  assign region_size        = rmap_ctrl_r[region_map_pkg::RSIZE_LO +: 4];
  assign user_ctrl_bits     = rmap_ctrl_r[region_map_pkg::UCTRL_LO +: 2];
  assign task_ident         = rmap_ctrl_r[region_map_pkg::TASK_LO +: 8];
  assign va_upper           = xlat_vaddr[region_map_pkg::VBASE_LO +: 16];
  assign va_lower           = xlat_vaddr[region_map_pkg::VBASE_LO-1:0];

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic [7:0] reg_index(input logic [9:0] addr);
    reg_index = addr[9:region_map_pkg::ADDR_LSB];
  endfunction : reg_index

  // one decode for both response paths keeps them in step
  function automatic logic reg_mapped(input logic [7:0] idx);
    case (idx)
      region_map_pkg::IDX_MMU_CONFIGURATION,
      region_map_pkg::IDX_REPLACEMENT_HINT,
      region_map_pkg::IDX_REGION_MAP_ADDRESS,
      region_map_pkg::IDX_REGION_MAP_CONTROL: reg_mapped = 1'b1;
      default:                                reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  // byte lanes without a strobe keep their old value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  // region sizes 0..15 ignore 16+n address bits
  assign keep_mask = 16'hffff << region_size;

  // ==========================================================
  // axi4-lite write path
  // ==========================================================
  logic       aw_held_r;
  logic       w_held_r;
  logic [9:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       bvalid_r;
  logic [1:0] bresp_r;
  logic       wr_fire;
  logic [9:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic       aw_have;
  logic       w_have;

  // nothing new is taken while a response waits for bready
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign aw_have = aw_held_r | (s_axi_awvalid & s_axi_awready);
  assign w_have  = w_held_r | (s_axi_wvalid & s_axi_wready);
  assign wr_fire = aw_have & w_have;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 10'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
    end else begin
      // hold whichever half arrived first until its partner comes
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= region_map_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= reg_mapped(reg_index(wr_addr)) ? region_map_pkg::RESP_OKAY
                                                 : region_map_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // software-visible control registers; hint is read only
  // base low bits are kept as written; keep_mask hides them from the compare and the output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r       <= region_map_pkg::CFG_RESET;
      rmap_addr_r <= region_map_pkg::ADDR_RESET;
      rmap_ctrl_r <= region_map_pkg::CTRL_RESET;
    end else if (wr_fire) begin
      case (reg_index(wr_addr))
        region_map_pkg::IDX_MMU_CONFIGURATION:
          cfg_r <= merge_bytes(cfg_r, wr_data, wr_strb) & region_map_pkg::CFG_MASK;
        region_map_pkg::IDX_REGION_MAP_ADDRESS:
          rmap_addr_r <= merge_bytes(rmap_addr_r, wr_data, wr_strb);
        region_map_pkg::IDX_REGION_MAP_CONTROL:
          rmap_ctrl_r <= merge_bytes(rmap_ctrl_r, wr_data, wr_strb)
                         & region_map_pkg::CTRL_MASK;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // axi4-lite read path
  // ==========================================================
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] hint_word;

  // hint names word 0 of the entry, hence the zero below it
  assign hint_word = 32'(hint_r) << region_map_pkg::HINT_LO;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= region_map_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= reg_mapped(reg_index(s_axi_araddr)) ? region_map_pkg::RESP_OKAY
                                                      : region_map_pkg::RESP_SLVERR;
      case (reg_index(s_axi_araddr))
        region_map_pkg::IDX_MMU_CONFIGURATION:  rdata_r <= cfg_r;
        region_map_pkg::IDX_REPLACEMENT_HINT:   rdata_r <= hint_word;
        region_map_pkg::IDX_REGION_MAP_ADDRESS: rdata_r <= rmap_addr_r;
        region_map_pkg::IDX_REGION_MAP_CONTROL: rdata_r <= rmap_ctrl_r;
        default: begin
          rdata_r <= 32'h0000_0000;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // page size and tlb task check
  // ==========================================================
  // a written page size reaches translation one cycle late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_size_r <= 2'h0;
    end else begin
      page_size_r <= cfg_r[region_map_pkg::PSIZE_LO +: 2];
    end
  end

  assign page_size_sel = page_size_r;
  assign page_shift    = region_map_pkg::PAGE_SHIFT_BASE + {3'h0, page_size_r};

  // left combinational: the tlb compares in the same cycle
  always_comb begin
    if (xlat_mode == region_map_pkg::MODE_USER) begin
      tlb_task_ok = (tlb_task_ident == current_process_id[PID_W-1:0]);
    end else begin
      tlb_task_ok = (tlb_task_ident == region_map_pkg::PID_ZERO[PID_W-1:0]);
    end
  end

  // ==========================================================
  // region unit
  // ==========================================================
  logic        privileged;
  logic        task_ok;
  logic        region_hit;
  logic        perm_ok;
  logic [15:0] upper_out;

  assign privileged = (xlat_mode != region_map_pkg::MODE_USER);
  assign task_ok = (task_ident == current_process_id)
                 | (privileged & (task_ident == region_map_pkg::PID_ZERO));
  assign region_hit = rmap_ctrl_r[region_map_pkg::VALID_BIT]
                    & (((va_upper ^ virt_base) & keep_mask) == 16'h0000)
                    & task_ok;
  assign upper_out = (phys_base & keep_mask) | (va_upper & ~keep_mask);

  // monitor mode borrows the supervisor permission bits
  always_comb begin
    perm_ok = 1'b0;
    case (xlat_kind)
      region_map_pkg::KIND_LOAD:
        perm_ok = privileged ? rmap_ctrl_r[region_map_pkg::SUP_READ_BIT]
                             : rmap_ctrl_r[region_map_pkg::USR_READ_BIT];
      region_map_pkg::KIND_STORE:
        perm_ok = privileged ? rmap_ctrl_r[region_map_pkg::SUP_WRITE_BIT]
                             : rmap_ctrl_r[region_map_pkg::USR_WRITE_BIT];
      region_map_pkg::KIND_FETCH:
        perm_ok = privileged ? rmap_ctrl_r[region_map_pkg::SUP_EXEC_BIT]
                             : rmap_ctrl_r[region_map_pkg::USR_EXEC_BIT];
      default: perm_ok = 1'b0;
    endcase
  end

  // a violation still reports the hit and its translated address
  logic is_fetch;
  logic viol_now;
  assign is_fetch = (xlat_kind == region_map_pkg::KIND_FETCH);
  assign viol_now = xlat_valid & region_hit & ~perm_ok;

  // status flags and the translated word are separate concerns
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid       <= 1'b0;
      res_region_hit  <= 1'b0;
      data_prot_viol  <= 1'b0;
      instr_prot_viol <= 1'b0;
    end else begin
      res_valid       <= xlat_valid;
      res_region_hit  <= xlat_valid & region_hit;
      data_prot_viol  <= viol_now & ~is_fetch;
      instr_prot_viol <= viol_now & is_fetch;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_paddr     <= 32'h0000_0000;
      res_io_space  <= 1'b0;
      user_ctrl_out <= 2'h0;
    end else if (xlat_valid && region_hit) begin
      res_paddr     <= {upper_out, va_lower};
      res_io_space  <= rmap_ctrl_r[region_map_pkg::IO_BIT];
      user_ctrl_out <= user_ctrl_bits;
    end else begin
      // untouched address passes through; pins idle low
      res_paddr     <= xlat_vaddr;
      res_io_space  <= 1'b0;
      user_ctrl_out <= 2'h0;
    end
  end

  // ==========================================================
  // replacement hint
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hint_r <= '0;
    end else if (tlb_miss || tlb_prot_viol || viol_now) begin
      // value is meaningless after a violation, but still loaded
      hint_r <= tlb_victim;
    end
  end

endmodule : region_map_translation

/* hw/region_map_pkg.sv */
package region_map_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_MMU_CONFIGURATION    = 8'h0d;
  localparam logic [7:0]  IDX_REPLACEMENT_HINT     = 8'h0e;
  localparam logic [7:0]  IDX_REGION_MAP_ADDRESS   = 8'h10;
  localparam logic [7:0]  IDX_REGION_MAP_CONTROL   = 8'h11;
  localparam int          ADDR_LSB                 = 2;
  // writable bit masks; everything else reads zero
  localparam logic [31:0] CFG_MASK                 = 32'h0000_03ff;
  localparam logic [31:0] CTRL_MASK                = 32'h00df_7fff;
  localparam logic [31:0] CFG_RESET                = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET               = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET               = 32'h0000_0000;
  // configuration fields
  localparam int          PSIZE_LO                 = 8;
  localparam int          PID_LO                   = 0;
  // replacement hint field
  localparam int          HINT_LO                  = 1;
  // region address fields
  localparam int          VBASE_LO                 = 16;
  localparam int          PBASE_LO                 = 0;
  // region control fields
  localparam int          UCTRL_LO                 = 22;
  localparam int          RSIZE_LO                 = 17;
  localparam int          IO_BIT                   = 16;
  localparam int          VALID_BIT                = 14;
  localparam int          SUP_READ_BIT             = 13;
  localparam int          SUP_WRITE_BIT            = 12;
  localparam int          SUP_EXEC_BIT             = 11;
  localparam int          USR_READ_BIT             = 10;
  localparam int          USR_WRITE_BIT            = 9;
  localparam int          USR_EXEC_BIT             = 8;
  localparam int          TASK_LO                  = 0;
  // page size 1 kb is 10 offset bits; region 64 kb is 16
  localparam logic [4:0]  PAGE_SHIFT_BASE          = 5'h0a;
  localparam logic [1:0]  RESP_OKAY                = 2'h0;
  localparam logic [1:0]  RESP_SLVERR              = 2'h2;
  localparam logic [7:0]  PID_ZERO                 = 8'h00;

  typedef enum logic [1:0] {MODE_USER, MODE_SUPERVISOR, MODE_MONITOR} mode_type;
  typedef enum logic [1:0] {KIND_LOAD, KIND_STORE, KIND_FETCH} kind_type;
endpackage : region_map_pkg

/* testbench/region_map_assertions.sv */
`timescale 1ns/10ps
// ==========
// port checks for the region translator
module region_map_assertions #(
  parameter int PID_W = 8
) (
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic                     xlat_valid,
  input wire logic [31:0]              xlat_vaddr,
  input wire region_map_pkg::mode_type xlat_mode,
  input wire region_map_pkg::kind_type xlat_kind,
  input wire logic [PID_W-1:0]         tlb_task_ident,
  input wire logic                     tlb_task_ok,
  input wire logic [1:0]               page_size_sel,
  input wire logic [4:0]               page_shift,
  input wire logic                     res_valid,
  input wire logic                     res_region_hit,
  input wire logic [31:0]              res_paddr,
  input wire logic                     res_io_space,
  input wire logic [1:0]               user_ctrl_out,
  input wire logic                     data_prot_viol,
  input wire logic                     instr_prot_viol
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_res_timing: assert property (1 |=> res_valid == $past(xlat_valid))
    else $error("result pulse not one cycle after request");
  chk_nohit_pass: assert property (res_valid && !res_region_hit |->
    res_paddr == $past(xlat_vaddr) && !res_io_space && user_ctrl_out == 2'h0)
    else $error("miss did not pass the address through");
  chk_hit_low: assert property (res_valid && res_region_hit |->
    res_paddr[15:0] == $past(xlat_vaddr[15:0]))
    else $error("low offset bits altered on a hit");
  chk_viol_hit: assert property (res_valid && (data_prot_viol || instr_prot_viol) |->
    res_region_hit)
    else $error("violation without a region hit");
  chk_data_kind: assert property (res_valid && data_prot_viol |->
    $past(xlat_kind) != region_map_pkg::KIND_FETCH)
    else $error("data violation on a fetch");
  chk_instr_kind: assert property (res_valid && instr_prot_viol |->
    $past(xlat_kind) == region_map_pkg::KIND_FETCH && !data_prot_viol)
    else $error("instruction violation not on a fetch");
  chk_page_shift: assert property (page_shift == 5'h0a + {3'h0, page_size_sel})
    else $error("page shift does not follow page size");
  chk_priv_task: assert property (xlat_valid && xlat_mode != region_map_pkg::MODE_USER |->
    tlb_task_ok == (tlb_task_ident == '0))
    else $error("privileged task check wrong");
  chk_io_space: assert property (res_valid && res_io_space |-> res_region_hit)
    else $error("io space without a hit");
endmodule : region_map_assertions

bind region_map_translation region_map_assertions #(.PID_W(PID_W)) chk_u (
  .mclk, .rst_n, .xlat_valid, .xlat_vaddr, .xlat_mode, .xlat_kind, .tlb_task_ident,
  .tlb_task_ok, .page_size_sel, .page_shift, .res_valid, .res_region_hit, .res_paddr,
  .res_io_space, .user_ctrl_out, .data_prot_viol, .instr_prot_viol
);

/* testbench/pipeline_model.sv */
`timescale 1ns/10ps
// ==========
// pipeline side: translation requests and tlb events
module pipeline_model (
  input  wire logic                mclk,
  output logic                     xlat_valid = 1'b0,
  output logic [31:0]              xlat_vaddr = 32'h0,
  output region_map_pkg::mode_type xlat_mode = region_map_pkg::MODE_USER,
  output region_map_pkg::kind_type xlat_kind = region_map_pkg::KIND_LOAD,
  output logic [7:0]               tlb_task_ident = 8'h0,
  output logic                     tlb_miss = 1'b0,
  output logic                     tlb_prot_viol = 1'b0,
  output logic [5:0]               tlb_victim = 6'h0
);
  // one-cycle request; address inverted after so nothing leans on a stale value
  task automatic issue(input logic [31:0] va, input logic [1:0] m, k, input logic [7:0] t);
    @(posedge mclk);
    xlat_valid     <= 1'b1;
    xlat_vaddr     <= va;
    xlat_mode      <= region_map_pkg::mode_type'(m);
    xlat_kind      <= region_map_pkg::kind_type'(k);
    tlb_task_ident <= t;
    @(posedge mclk);
    xlat_valid     <= 1'b0;
    xlat_vaddr     <= ~va;
  endtask : issue

  task automatic flag(input logic [5:0] v, input logic viol);
    @(posedge mclk);
    tlb_miss      <= ~viol;
    tlb_prot_viol <= viol;
    tlb_victim    <= v;
    @(posedge mclk);
    tlb_miss      <= 1'b0;
    tlb_prot_viol <= 1'b0;
    tlb_victim    <= ~v;
  endtask : flag
endmodule : pipeline_model

/* testbench/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  localparam logic [9:0] A_CFG = 10'h034, A_HINT = 10'h038;
  localparam logic [9:0] A_ADDR = 10'h040, A_CTRL = 10'h044;
  localparam logic [1:0] OK = 2'h0;
  logic        mclk = 1'b0, rst_n = 1'b0;
  logic [9:0]  s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, xlat_vaddr, res_paddr;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, page_size_sel, user_ctrl_out, bresp_seen;
  logic [7:0]  tlb_task_ident;
  logic [5:0]  tlb_victim;
  logic [4:0]  page_shift;
  logic        xlat_valid, tlb_miss, tlb_prot_viol, tlb_task_ok, res_valid;
  logic        res_region_hit, res_io_space, data_prot_viol, instr_prot_viol;
  region_map_pkg::mode_type xlat_mode;
  region_map_pkg::kind_type xlat_kind;
  int          bad_count = 0, cmp_count = 0, cyc = 0;

  region_map_translation dut_u (
    .mclk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .xlat_valid, .xlat_vaddr, .xlat_mode, .xlat_kind, .tlb_task_ident, .tlb_miss,
    .tlb_prot_viol, .tlb_victim, .tlb_task_ok, .page_size_sel, .page_shift, .res_valid,
    .res_region_hit, .res_paddr, .res_io_space, .user_ctrl_out, .data_prot_viol,
    .instr_prot_viol
  );
  pipeline_model pipe_u (
    .mclk, .xlat_valid, .xlat_vaddr, .xlat_mode, .xlat_kind, .tlb_task_ident,
    .tlb_miss, .tlb_prot_viol, .tlb_victim
  );

  // ==========
  // bus and request helpers
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_bvalid) break;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_rvalid) break;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    `CHK({s_axi_rresp, s_axi_rdata}, {r, e})
  endtask : rd

  // mode 0 user 1 supervisor 2 monitor; kind 0 load 1 store 2 fetch; e is hit, dviol, iviol
  task automatic xl(input logic [31:0] va, input logic [1:0] m, k, input logic [7:0] t,
                    input logic [2:0] e, input logic [31:0] pa);
    pipe_u.issue(va, m, k, t);
    #1;
    `CHK({res_valid, res_region_hit, data_prot_viol, instr_prot_viol, res_paddr}, {1'b1, e, pa})
  endtask : xl

  // ==========
  // scenarios
  task automatic t_regs();
    rd(A_CFG, 32'h0, OK);
    wr(A_CFG, 32'hffff_ffff);
    rd(A_CFG, 32'h0000_03ff, OK);
    wr(A_CTRL, 32'hffff_ffff);
    rd(A_CTRL, 32'h00df_7fff, OK);
    wr(A_HINT, 32'hffff_ffff);
    `CHK(bresp_seen, OK)
    rd(A_HINT, 32'h0, OK);
    wr(10'h03c, 32'hffff_ffff);
    `CHK(bresp_seen, region_map_pkg::RESP_SLVERR)
    rd(10'h03c, 32'h0, region_map_pkg::RESP_SLVERR);
  endtask : t_regs

  task automatic t_page();
    for (int p = 0; p < 4; p++) begin
      wr(A_CFG, {22'h0, p[1:0], 8'h05});
      repeat (2) @(posedge mclk);
      #1;
      `CHK({page_size_sel, page_shift}, {p[1:0], 5'h0a + 5'(p)})
    end
  endtask : t_page

  task automatic t_hint();
    pipe_u.flag(6'h2a, 1'b0);
    rd(A_HINT, 32'h0000_0054, OK);
    pipe_u.flag(6'h15, 1'b1);
    rd(A_HINT, 32'h0000_002a, OK);
  endtask : t_hint

  task automatic t_region();
    wr(A_ADDR, 32'h1234_abcd);
    wr(A_CTRL, 32'h0081_7f05);
    xl(32'h1234_5678, 2'd0, 2'd0, 8'h05, 3'b100, 32'habcd_5678);
    `CHK({res_io_space, user_ctrl_out}, 3'b110)
    xl(32'h1235_0000, 2'd0, 2'd0, 8'h05, 3'b000, 32'h1235_0000);
    wr(A_ADDR, 32'h1234_abcc);
    wr(A_CTRL, 32'h0042_7f05);
    xl(32'h1235_0010, 2'd0, 2'd1, 8'h05, 3'b100, 32'habcd_0010);
    `CHK({res_io_space, user_ctrl_out}, 3'b001)
    wr(A_ADDR, 32'h8000_0000);
    wr(A_CTRL, 32'h001e_7f05);
    xl(32'hffff_0000, 2'd0, 2'd2, 8'h05, 3'b100, 32'h7fff_0000);
    wr(A_CTRL, 32'h001e_3f05);
    xl(32'hffff_0000, 2'd0, 2'd0, 8'h05, 3'b000, 32'hffff_0000);
  endtask : t_region

  task automatic t_perm();
    logic [1:0] k;
    for (int b = 8; b < 14; b++) begin
      k = 2'((13 - b) % 3);
      wr(A_CTRL, 32'h001e_7f05 & ~(32'h1 << b));
      xl(32'hffff_0000, 2'(b > 10), k, 8'h05, {1'b1, k != 2'd2, k == 2'd2}, 32'h7fff_0000);
      wr(A_CTRL, 32'h001e_7f05);
      xl(32'hffff_0000, 2'(b > 10), k, 8'h05, 3'b100, 32'h7fff_0000);
    end
  endtask : t_perm

  task automatic t_task();
    wr(A_CTRL, 32'h001e_7f00);
    xl(32'hffff_0000, 2'd0, 2'd0, 8'h05, 3'b000, 32'hffff_0000);
    `CHK(tlb_task_ok, 1'b1)
    xl(32'hffff_0000, 2'd1, 2'd1, 8'h00, 3'b100, 32'h7fff_0000);
    `CHK(tlb_task_ok, 1'b1)
    xl(32'hffff_0000, 2'd2, 2'd2, 8'h05, 3'b100, 32'h7fff_0000);
    `CHK(tlb_task_ok, 1'b0)
    wr(A_CTRL, 32'h001e_7f07);
    xl(32'hffff_0000, 2'd0, 2'd0, 8'h06, 3'b000, 32'hffff_0000);
    `CHK(tlb_task_ok, 1'b0)
  endtask : t_task

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  // ==========
  // clock, reset, sequence, hang guard
  initial begin
    forever #25 mclk = ~mclk;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_page();
    t_hint();
    t_region();
    t_perm();
    t_task();
    conclude();
  end
  // whole run is under two hundred cycles; ceiling leaves wide margin
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
endmodule : testbench
